/* File: srt_pkg.sv */
// shared constants for the set/reset/toggle relay block
package srt_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam int ADDR_W = 4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DOM_BIT = 2;
  localparam int STATUS_Q_BIT = 0;
  localparam int STATUS_SET_BIT = 1;
  localparam int STATUS_RST_BIT = 2;
  localparam int STATUS_TRG_BIT = 3;
  localparam int STATUS_REST_BIT = 4;

  // ----------------------------------------------------------------
  // reset values and ahb-lite codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic DOM_RESET = 1'b0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // modes and input sampler layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LATCH,
    MODE_TOGGLE,
    MODE_LEGACY
  } srt_mode_t;

  localparam int IN_SET = 0;
  localparam int IN_RST = 1;
  localparam int IN_TRG = 2;
  localparam int IN_COUNT = 3;

endpackage

/* File: srt_sampler.sv */
// per-cycle input sampler with rising edge detection
`timescale 1ns/1ps
`default_nettype none

module srt_sampler #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // raw inputs
  input wire logic [WIDTH-1:0] raw_in,
  // sampled level and edge
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] prev;

  // elaboration check: the edge compare needs at least one input
  if (WIDTH < 1) begin : g_width_check
    $error("srt_sampler needs at least one input");
  end

  // sample once per cycle and keep the last sample for edge compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level <= '0;
      prev <= '0;
    end else begin
      level <= raw_in;
      prev <= level;
    end
  end

  // a rise is a high sample whose previous sample was low
  assign rise = level & ~prev;

endmodule

`default_nettype wire

/* File: srt_relay.sv */
// set/reset latch and toggle relay with ahb-lite control registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module srt_relay (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // neighbouring control logic
  input wire logic set_in,
  input wire logic reset_in,
  input wire logic trigger_in,
  input wire logic retain_en,
  // relay output
  output logic q
);

  // ----------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------
  logic [srt_pkg::IN_COUNT-1:0] lvl;
  logic [srt_pkg::IN_COUNT-1:0] rise;

  srt_sampler #(
    .WIDTH(srt_pkg::IN_COUNT)
  ) u_sampler (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw_in({trigger_in, reset_in, set_in}),
    .level(lvl),
    .rise(rise)
  );

  // named taps into the sampled word
  logic s_lvl;
  logic r_lvl;
  logic t_rise;
  assign s_lvl = lvl[srt_pkg::IN_SET];
  assign r_lvl = lvl[srt_pkg::IN_RST];
  assign t_rise = rise[srt_pkg::IN_TRG];

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [1:0] mode_bits;
  logic set_dom;
  logic restored;
  logic wr_pend;
  logic [srt_pkg::ADDR_W-1:0] wr_addr;
  logic addr_ok;

  function automatic srt_pkg::srt_mode_t decode_mode(input logic [1:0] bits);
    // code three is not a mode; fall back to the plain latch
    if (bits == 2'h1) begin
      decode_mode = srt_pkg::MODE_TOGGLE;
    end else if (bits == 2'h2) begin
      decode_mode = srt_pkg::MODE_LEGACY;
    end else begin
      decode_mode = srt_pkg::MODE_LATCH;
    end
  endfunction

  // mode decoded once so every process sees the same value
  srt_pkg::srt_mode_t mode;
  assign mode = decode_mode(mode_bits);

  // only a selected nonseq transfer with the bus ready starts a phase
  assign addr_ok = hsel && hready && (htrans == srt_pkg::HTRANS_NONSEQ);

  // zero wait state slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= srt_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= srt_pkg::HRESP_OKAY;
    end
  end

  // remember the write address phase; data follows next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[srt_pkg::ADDR_W-1:0];
    end
  end

  // control register; unmapped writes fall away silently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_bits <= srt_pkg::MODE_RESET;
      set_dom <= srt_pkg::DOM_RESET;
    end else if (wr_pend && wr_addr == srt_pkg::CTRL_OFFSET[srt_pkg::ADDR_W-1:0]) begin
      mode_bits <= hwdata[srt_pkg::CTRL_MODE_LSB +: 2];
      set_dom <= hwdata[srt_pkg::CTRL_DOM_BIT];
    end
  end

  // read data captured at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= srt_pkg::RDATA_RESET;
    end else if (addr_ok && !hwrite) begin
      if (haddr[srt_pkg::ADDR_W-1:0] == srt_pkg::CTRL_OFFSET[srt_pkg::ADDR_W-1:0]) begin
        hrdata <= '0;
        hrdata[srt_pkg::CTRL_MODE_LSB +: 2] <= mode_bits;
        hrdata[srt_pkg::CTRL_DOM_BIT] <= set_dom;
      end else if (haddr[srt_pkg::ADDR_W-1:0] ==
                   srt_pkg::STATUS_OFFSET[srt_pkg::ADDR_W-1:0]) begin
        hrdata <= '0;
        hrdata[srt_pkg::STATUS_Q_BIT] <= q;
        hrdata[srt_pkg::STATUS_SET_BIT] <= s_lvl;
        hrdata[srt_pkg::STATUS_RST_BIT] <= r_lvl;
        hrdata[srt_pkg::STATUS_TRG_BIT] <= lvl[srt_pkg::IN_TRG];
        hrdata[srt_pkg::STATUS_REST_BIT] <= restored;
      end else begin
        hrdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // retention
  // ----------------------------------------------------------------
  // awake drops with reset and rises one edge after release
  logic awake;
  logic kept_q;

  // first cycle after release is the restore slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      awake <= 1'b0;
    end else begin
      awake <= 1'b1;
    end
  end

  // no reset here on purpose: this cell stands in for battery-backed memory
  // and freezes while the block is held down, so the last value survives
  always_ff @(posedge hclk) begin
    if (awake) begin
      kept_q <= q;
    end
  end

  // flag for software that the output was brought back from memory
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restored <= 1'b0;
    end else if (!awake) begin
      restored <= retain_en && kept_q;
    end
  end

  // ----------------------------------------------------------------
  // relay core
  // ----------------------------------------------------------------
  logic next_q;

  // next output per mode; levels hold a forced value as long as they stay high
  always_comb begin
    next_q = q;
    case (mode)
      srt_pkg::MODE_LATCH: begin
        if (r_lvl) begin
          next_q = 1'b0;
        end else if (s_lvl) begin
          next_q = 1'b1;
        end else begin
          next_q = q;
        end
      end
      srt_pkg::MODE_TOGGLE: begin
        if (set_dom && s_lvl) begin
          next_q = 1'b1;
        end else if (r_lvl) begin
          next_q = 1'b0;
        end else if (s_lvl) begin
          next_q = 1'b1;
        end else if (t_rise) begin
          next_q = ~q;
        end else begin
          next_q = q;
        end
      end
      srt_pkg::MODE_LEGACY: begin
        // no set input and no priority choice here
        if (r_lvl) begin
          next_q = 1'b0;
        end else if (t_rise) begin
          next_q = ~q;
        end else begin
          next_q = q;
        end
      end
      default: begin
        next_q = q;
      end
    endcase
  end

  // output flop; restore slot picks memory only when retention is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= 1'b0;
    end else if (!awake) begin
      q <= retain_en && kept_q;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // one clock domain; checks pause while the block is held in reset
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // latch: reset always wins, set drives high, idle holds
  latch_set_a: assert property (awake && mode == srt_pkg::MODE_LATCH
    && s_lvl && !r_lvl |=> q) else $error("latch did not set");
  latch_reset_a: assert property (awake && mode == srt_pkg::MODE_LATCH
    && r_lvl |=> !q) else $error("latch did not reset");
  latch_hold_a: assert property (awake && mode == srt_pkg::MODE_LATCH
    && !s_lvl && !r_lvl |=> $stable(q)) else $error("latch lost its state");

  // toggle: an edge flips the output only while both levels are low
  toggle_flip_a: assert property (awake && mode == srt_pkg::MODE_TOGGLE && t_rise
    && !s_lvl && !r_lvl |=> q != $past(q)) else $error("toggle missed edge");
  toggle_block_a: assert property (awake && mode == srt_pkg::MODE_TOGGLE && !t_rise
    && !s_lvl && !r_lvl |=> $stable(q)) else $error("toggle moved without edge");

  // toggle: levels beat edges, and the chosen input dominates the other
  toggle_ignore_a: assert property (awake && mode == srt_pkg::MODE_TOGGLE && t_rise
    && (s_lvl || r_lvl) |=> q == $past((set_dom && s_lvl) || !r_lvl))
    else $error("toggle took an edge under set or reset");
  toggle_set_a: assert property (awake && mode == srt_pkg::MODE_TOGGLE
    && s_lvl && !r_lvl |=> q) else $error("toggle set did not force one");
  toggle_clear_a: assert property (awake && mode == srt_pkg::MODE_TOGGLE
    && r_lvl && !s_lvl |=> !q) else $error("toggle reset did not clear");
  set_dom_a: assert property (awake && mode == srt_pkg::MODE_TOGGLE && set_dom
    && s_lvl ##1 s_lvl [*2] |-> q) else $error("set dominance broken");
  rst_dom_a: assert property (awake && mode == srt_pkg::MODE_TOGGLE && !set_dom
    && r_lvl |=> !q) else $error("reset dominance broken");

  // legacy: no set input, reset beats the trigger
  legacy_off_a: assert property (awake && mode == srt_pkg::MODE_LEGACY
    && r_lvl |=> !q) else $error("legacy reset failed");
  legacy_flip_a: assert property (awake && mode == srt_pkg::MODE_LEGACY
    && t_rise && !r_lvl |=> q != $past(q)) else $error("legacy missed edge");
  legacy_noset_a: assert property (awake && mode == srt_pkg::MODE_LEGACY
    && !t_rise && !r_lvl |=> $stable(q)) else $error("legacy moved without edge");

  // power-up: the restore slot loads memory only with retention on
  restore_a: assert property (!awake |=> q == $past(retain_en && kept_q))
    else $error("restore value wrong");
  cold_start_a: assert property (!awake && !retain_en |=> !q)
    else $error("output not cleared after reset");

  // sampler: an edge needs a low sample before a high one
  edge_src_a: assert property (t_rise |-> lvl[srt_pkg::IN_TRG]
    && $past(lvl[srt_pkg::IN_TRG]) == 1'b0) else $error("edge not from previous sample");

  // main scenarios worth seeing at least once
  toggle_cover: cover property (mode == srt_pkg::MODE_TOGGLE && t_rise ##[1:20] t_rise);
  restore_cover: cover property (!awake && retain_en && kept_q);
  legacy_cover: cover property (mode == srt_pkg::MODE_LEGACY && t_rise ##[1:20] r_lvl);
  dom_cover: cover property (mode == srt_pkg::MODE_TOGGLE && set_dom && s_lvl && r_lvl);

endmodule

`default_nettype wire

/* File: srt_ctl_model.sv */
// model of the neighbouring control logic that drives set, reset and trigger
`timescale 1ns/1ps
`default_nettype none

module srt_ctl_model (
  // clock
  input wire logic hclk,
  // control levels towards the relay
  output logic set_o,
  output logic reset_o,
  output logic trigger_o
);
  // ----------------------------------------------------------------
  // level driver
  // ----------------------------------------------------------------
  // all levels low at power-up so no false trigger rise
  initial begin
    set_o = 1'b0;
    reset_o = 1'b0;
    trigger_o = 1'b0;
  end

  // levels change just after an edge and stand for whole cycles
  task automatic drive(input logic [2:0] v);
    @(posedge hclk);
    {trigger_o, reset_o, set_o} <= v;
  endtask
endmodule

`default_nettype wire

/* File: set_reset_toggle_relay_bench.sv */
// self-checking bench for the set/reset/toggle relay
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end

module set_reset_toggle_relay_bench;
  // ----------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic retain_en = 1'b0;
  logic q;
  logic set_w;
  logic rst_w;
  logic trg_w;
  int failures = 0;
  int checks = 0;
  logic model_q = 1'b0;
  logic prev_t = 1'b0;
  logic [31:0] ctl = 32'h0;
  logic [31:0] ctl_tab [5] = '{32'h0, 32'h1, 32'h5, 32'h2, 32'h7};
  logic [2:0] corner [12] = '{3'h2, 3'h4, 3'h0, 3'h4, 3'h5, 3'h1, 3'h0, 3'h3, 3'h7,
                              3'h6, 3'h4, 3'h0};
  logic [31:0] ret_ctl [4] = '{32'h0, 32'h1, 32'h2, 32'h0};
  logic [2:0] ret_vec [4] = '{3'h1, 3'h4, 3'h4, 3'h1};
  logic ret_en [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  always #2.5 hclk = ~hclk;

  srt_ctl_model partner_u (.hclk(hclk), .set_o(set_w), .reset_o(rst_w), .trigger_o(trg_w));

  srt_relay dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .set_in(set_w), .reset_in(rst_w),
    .trigger_in(trg_w), .retain_en(retain_en), .q(q)
  );

  // ----------------------------------------------------------------
  // reference model and bus tasks
  // ----------------------------------------------------------------
  // v is {trigger, reset, set}; a rise needs a low sample before it
  function automatic logic next_q(logic [31:0] c, logic [2:0] v, logic q0, logic pt);
    logic rise;
    rise = v[2] & ~pt;
    if (c[1:0] == 2'h2) return v[1] ? 1'b0 : (rise ? ~q0 : q0);
    if (c[1:0] != 2'h1) return v[1] ? 1'b0 : (v[0] ? 1'b1 : q0);
    if (c[2] && v[0]) return 1'b1;
    if (v[1]) return 1'b0;
    if (v[0]) return 1'b1;
    return rise ? ~q0 : q0;
  endfunction

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        failures++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= srt_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    `CHK("hresp", srt_pkg::HRESP_OKAY, hresp)
  endtask

  // one input vector, held long enough for sample and output flops
  task automatic step(input logic [2:0] v, input logic rd_st);
    logic [31:0] rd;
    partner_u.drive(v);
    model_q = next_q(ctl, v, model_q, prev_t);
    prev_t = v[2];
    repeat (3) @(posedge hclk);
    #1;
    `CHK("q", model_q, q)
    if (rd_st) begin
      ahb(1'b0, srt_pkg::STATUS_OFFSET, 32'h0, rd);
      `CHK("status", {v, model_q}, rd[3:0])
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    void'($urandom(32'haaf45ec6));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, srt_pkg::CTRL_OFFSET, 32'h0, rd);
    `CHK("ctrl reset", srt_pkg::RDATA_RESET, rd)
    ahb(1'b0, 32'h8, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("test registers done");
    // each mode: corner vectors first, then random traffic
    for (int m = 0; m < 5; m++) begin
      step(3'h0, 1'b0);
      ahb(1'b1, srt_pkg::CTRL_OFFSET, ctl_tab[m], rd);
      ctl = ctl_tab[m];
      foreach (corner[i]) step(corner[i], 1'b0);
      for (int i = 0; i < 40; i++) step(3'($urandom_range(7)), ($urandom_range(3) == 0));
      $display("test mode %0d done", m);
    end
    // power loss modelled by reset, with and without retention
    for (int k = 0; k < 4; k++) begin
      step(3'h0, 1'b0);
      ahb(1'b1, srt_pkg::CTRL_OFFSET, ret_ctl[k], rd);
      ctl = ret_ctl[k];
      step(3'h2, 1'b0);
      step(ret_vec[k], 1'b0);
      step(3'h0, 1'b0);
      @(posedge hclk);
      retain_en <= ret_en[k];
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      #1;
      `CHK("q restored", ret_en[k], q)
      ahb(1'b0, srt_pkg::STATUS_OFFSET, 32'h0, rd);
      `CHK("restored flag", ret_en[k], rd[4])
      retain_en <= 1'b0;
      model_q = ret_en[k];
      prev_t = 1'b0;
      ctl = 32'h0;
      ahb(1'b0, srt_pkg::CTRL_OFFSET, 32'h0, rd);
      `CHK("ctrl after reset", 32'h0, rd)
    end
    $display("test retention done");
    test_done();
  end

  // watchdog against a hung run
  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    test_done();
  end
endmodule

`default_nettype wire
